/* verilog/arc_pkg.sv */
// ==========================================================
// Shared constants for the adaptive receiver controller
package arc_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_TABLE_LAST = 8'h13;
	localparam logic [7:0] ADDR_MODE = 8'h80;
	localparam logic [7:0] ADDR_RXCTL = 8'h81;
	localparam logic [7:0] ADDR_SIGPRO = 8'h82;
	localparam logic [7:0] ADDR_SYSCFG = 8'h83;
	localparam logic [7:0] ADDR_SEND_INSTR = 8'h84;
	localparam logic [7:0] ADDR_STATUS = 8'h85;
	localparam logic [7:0] ADDR_SIZE = 8'h97;
	// ==========================================================
	// Table layout and capacity
	localparam int TABLE_DEPTH = 20;
	localparam logic [4:0] TABLE_END = 5'h14;
	localparam int MASK_LSB = 16;
	localparam int MINP_LSB = 13;
	localparam int MIN_LSB = 10;
	localparam int GAIN_LSB = 7;
	localparam int HPCF_LSB = 4;
	localparam int GEAR_LSB = 0;
	// ==========================================================
	// Field widths, limits, reset values
	localparam logic [3:0] GAIN_MAX = 4'h3;
	localparam logic [3:0] HPCF_MAX = 4'h3;
	localparam logic [3:0] MIN_MAX = 4'hF;
	localparam logic [7:0] SIZE_RESET = 8'h00;
	localparam logic [3:0] FIELD_RESET = 4'h0;
	localparam logic [15:0] MODE_RESET = 16'h0001;
	// ==========================================================
	// System configuration fields
	localparam logic [2:0] CMD_IDLE = 3'h0;
	localparam logic [2:0] CMD_TRANSCEIVE = 3'h3;
	localparam int START_SEND_BIT = 3;
	// ==========================================================
	// State encodings
	typedef enum logic [1:0] {
		ARC_IDLE = 2'b01,
		ARC_SCAN = 2'b10
	} arc_state_t;
	typedef enum logic [3:0] {
		TRX_IDLE = 4'b0001,
		TRX_WAIT_TX = 4'b0010,
		TRX_TX = 4'b0100,
		TRX_RX = 4'b1000
	} arc_trx_state_t;
endpackage

/* verilog/arc_adaptive_rx.sv */
// Overview of operation
// R1: Gear changes update only receiver gain, high-pass corner and both min levels.
// R2: Adaptive table entry count comes from upper nibble of size entry.
// R3: Zero adaptive table size disables all receiver updates on gear changes.
// R4: Both tables share twenty word entries plus one length byte.
// R5: Adaptive table starts right after the last waveshaping entry.
// R6: Host changing waveshaping size shifts and invalidates stored receiver entries.
// R7: Adaptive values override receiver defaults written at protocol load.
// R8: Each gear switch searches table and applies matching entry to config.
// R9: Upper sixteen entry bits are a one-hot technology and rate mask.
// R10: Bits 15 to 13 change secondary min level by up to three.
// R11: Bits 12 to 10 change primary min level by up to three.
// R12: Bits 9 to 7 change receiver gain by up to three.
// R13: Bits 6 to 4 change high-pass corner by up to three.
// R14: Bits 3 to 0 hold the gear where the entry applies.
// R15: One transceive command sends, then receives the expected response.
// R16: Writing transceive code into command field starts the transceive machine.
// R17: A started transceive machine never returns to idle by itself.
// R18: Host stops the machine after an error by writing idle code.
// R19: Send-start bit or send-data instruction both trigger transmission.
// R20: Sign bit zero adds magnitude, one subtracts it.
// R21: Changes accumulate across successive applicable entries as gear rises.
// R22: Software stores entries with gear numbers in ascending order.
// R23: Results beyond a field's range clamp to its minimum or maximum.
// R24: Entry matches only on equal gear and set mask bit for mode.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module arc_adaptive_rx
	import arc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Power control gear
	input wire logic [3:0] dpc_gear,
	// RF front end handshake
	input wire logic tx_done,
	input wire logic rx_done,
	// Receiver settings
	output logic [1:0] rx_gain,
	output logic [1:0] highpass_corner_field,
	output logic [3:0] primary_min_threshold,
	output logic [3:0] secondary_min_threshold,
	// Transceive control
	output logic tx_start,
	output logic rx_enable,
	output logic trx_active
);
	// ==========================================================
	// Clamped relative update
	function automatic logic [3:0] apply_delta(input logic [3:0] cur, input logic [2:0] d,
		input logic [3:0] maxv);
		logic [4:0] mag;
		logic [4:0] sum;
		mag = {3'h0, d[1:0]};
		sum = {1'b0, cur} + mag;
		// R20 sign selects add or subtract
		if (!d[2]) begin
			// R23 clamp at top
			apply_delta = (sum > {1'b0, maxv}) ? maxv : sum[3:0];
		end else begin
			// R23 clamp at zero
			apply_delta = (mag > {1'b0, cur}) ? 4'h0 : 4'(cur - mag[3:0]);
		end
	endfunction
	// ==========================================================
	// Storage
	logic [31:0] table_mem [TABLE_DEPTH];
	logic [7:0] shaping_table_size_entry;
	logic [15:0] active_mode;
	logic [2:0] sys_command;
	arc_state_t arc_state;
	arc_trx_state_t trx_state;
	logic [3:0] gear_q;
	logic [3:0] target_gear;
	logic [4:0] scan_idx;
	logic [3:0] scan_left;
	// Decode
	wire logic table_sel = (reg_addr <= ADDR_TABLE_LAST);
	wire logic wr_table = reg_wr && table_sel;
	wire logic wr_mode = reg_wr && (reg_addr == ADDR_MODE);
	wire logic wr_rxctl = reg_wr && (reg_addr == ADDR_RXCTL);
	wire logic wr_sigpro = reg_wr && (reg_addr == ADDR_SIGPRO);
	wire logic wr_syscfg = reg_wr && (reg_addr == ADDR_SYSCFG);
	wire logic wr_instr = reg_wr && (reg_addr == ADDR_SEND_INSTR);
	wire logic wr_size = reg_wr && (reg_addr == ADDR_SIZE);
	// R2 adaptive size in upper nibble, shaping size in lower
	wire logic [3:0] arc_size = shaping_table_size_entry[7:4];
	wire logic [3:0] shape_size = shaping_table_size_entry[3:0];
	// ==========================================================
	// Table entry fields
	wire logic [31:0] entry = (scan_idx < TABLE_END) ? table_mem[scan_idx] : 32'h0;
	wire logic [15:0] entry_mask = entry[MASK_LSB +: 16];
	wire logic [2:0] entry_minp = entry[MINP_LSB +: 3];
	wire logic [2:0] entry_min = entry[MIN_LSB +: 3];
	wire logic [2:0] entry_gain = entry[GAIN_LSB +: 3];
	wire logic [2:0] entry_hpcf = entry[HPCF_LSB +: 3];
	wire logic [3:0] entry_gear = entry[GEAR_LSB +: 4];
	// R4 scan stops at end of shared capacity
	wire logic scan_done = (scan_left == 4'h0) || (scan_idx >= TABLE_END);
	// R24 gear equal and mode bit set; R9 one-hot mask; R14 gear field
	wire logic hit = (entry_gear == target_gear) && |(entry_mask & active_mode);
	wire logic apply = (arc_state == ARC_SCAN) && !scan_done && hit;
	wire logic gear_changed = (dpc_gear != gear_q);
	wire logic scan_start = (arc_state == ARC_IDLE) && gear_changed && (arc_size != 4'h0);
	// R10 R11 R12 R13 clamped field updates
	wire logic [3:0] adj_gain = apply_delta({2'h0, rx_gain}, entry_gain, GAIN_MAX);
	wire logic [3:0] adj_hpcf = apply_delta({2'h0, highpass_corner_field}, entry_hpcf,
		HPCF_MAX);
	wire logic [3:0] adj_min = apply_delta(primary_min_threshold, entry_min, MIN_MAX);
	wire logic [3:0] adj_minp = apply_delta(secondary_min_threshold, entry_minp, MIN_MAX);
	// ==========================================================
	// Table and size writes
	always_ff @(posedge clock) begin
		if (wr_table) begin
			table_mem[reg_addr[4:0]] <= reg_wdata;
		end
	end
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			shaping_table_size_entry <= SIZE_RESET;
			active_mode <= MODE_RESET;
		end else begin
			if (wr_size) begin
				shaping_table_size_entry <= reg_wdata[7:0];
			end
			if (wr_mode) begin
				active_mode <= reg_wdata[15:0];
			end
		end
	end
	// ==========================================================
	// Gear search machine
	arc_state_t next_arc_state;
	always_comb begin
		next_arc_state = arc_state;
		case (arc_state)
			ARC_IDLE: begin
				// R3 zero size never starts a search
				if (scan_start) begin
					next_arc_state = ARC_SCAN;
				end
			end
			ARC_SCAN: begin
				if (scan_done) begin
					next_arc_state = ARC_IDLE;
				end
			end
			default: next_arc_state = ARC_IDLE;
		endcase
	end

	// R8 walk entries on each gear switch
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			arc_state <= ARC_IDLE;
			gear_q <= 4'h0;
			target_gear <= 4'h0;
			scan_idx <= 5'h00;
			scan_left <= 4'h0;
		end else begin
			arc_state <= next_arc_state;
			if (arc_state == ARC_IDLE) begin
				gear_q <= dpc_gear;
			end
			if (scan_start) begin
				target_gear <= dpc_gear;
				// R5 start right after waveshaping entries
				scan_idx <= {1'b0, shape_size};
				scan_left <= arc_size;
			end else if (arc_state == ARC_SCAN && !scan_done) begin
				scan_idx <= scan_idx + 5'h01;
				scan_left <= scan_left - 4'h1;
			end
		end
	end

	// ==========================================================
	// Receiver settings; R1 only these four fields move
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rx_gain <= 2'h0;
			highpass_corner_field <= 2'h0;
			primary_min_threshold <= FIELD_RESET;
			secondary_min_threshold <= FIELD_RESET;
		end else if (apply) begin
			// R7 adaptive update wins over protocol defaults; R21 builds on current
			rx_gain <= adj_gain[1:0];
			highpass_corner_field <= adj_hpcf[1:0];
			primary_min_threshold <= adj_min;
			secondary_min_threshold <= adj_minp;
		end else begin
			if (wr_rxctl) begin
				rx_gain <= reg_wdata[3:2];
				highpass_corner_field <= reg_wdata[1:0];
			end
			if (wr_sigpro) begin
				secondary_min_threshold <= reg_wdata[7:4];
				primary_min_threshold <= reg_wdata[3:0];
			end
		end
	end

	// ==========================================================
	// Transceive machine
	wire logic cmd_trx = wr_syscfg && (reg_wdata[2:0] == CMD_TRANSCEIVE);
	wire logic cmd_idle = wr_syscfg && (reg_wdata[2:0] == CMD_IDLE);
	// R19 either trigger starts sending
	wire logic send_trig = wr_instr || (wr_syscfg && reg_wdata[START_SEND_BIT]);
	arc_trx_state_t next_trx_state;
	always_comb begin
		next_trx_state = trx_state;
		case (trx_state)
			TRX_IDLE: begin
				// R16 transceive code starts the machine
				if (cmd_trx) begin
					next_trx_state = TRX_WAIT_TX;
				end
			end
			TRX_WAIT_TX: begin
				if (send_trig) begin
					next_trx_state = TRX_TX;
				end
			end
			TRX_TX: begin
				// R15 receive follows transmit
				if (tx_done) begin
					next_trx_state = TRX_RX;
				end
			end
			TRX_RX: begin
				// R17 loop back, never to idle
				if (rx_done) begin
					next_trx_state = TRX_WAIT_TX;
				end
			end
			default: next_trx_state = TRX_IDLE;
		endcase
		// R18 host idle command stops it
		if (cmd_idle) begin
			next_trx_state = TRX_IDLE;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			trx_state <= TRX_IDLE;
			sys_command <= CMD_IDLE;
			tx_start <= 1'b0;
			rx_enable <= 1'b0;
			trx_active <= 1'b0;
		end else begin
			trx_state <= next_trx_state;
			if (wr_syscfg) begin
				sys_command <= reg_wdata[2:0];
			end
			tx_start <= (trx_state == TRX_WAIT_TX) && send_trig && !cmd_idle;
			rx_enable <= (next_trx_state == TRX_RX);
			trx_active <= (next_trx_state != TRX_IDLE);
		end
	end

	// ==========================================================
	// Read port, data in the cycle after the strobe
	wire logic [31:0] status_word = {20'h0, trx_state, 2'h0, arc_state, gear_q};
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0;
		if (table_sel) begin
			next_rdata = table_mem[reg_addr[4:0]];
		end else begin
			case (reg_addr)
				ADDR_MODE: next_rdata = {16'h0, active_mode};
				ADDR_RXCTL: next_rdata = {28'h0, rx_gain, highpass_corner_field};
				ADDR_SIGPRO: next_rdata = {24'h0, secondary_min_threshold, primary_min_threshold};
				ADDR_SYSCFG: next_rdata = {29'h0, sys_command};
				ADDR_STATUS: next_rdata = status_word;
				ADDR_SIZE: next_rdata = {24'h0, shaping_table_size_entry};
				default: next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 32'h0;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_size_zero;
		(arc_state == ARC_IDLE) && (arc_size == 4'h0) |=> (arc_state == ARC_IDLE);
	endproperty
	a_size_zero: assert property (p_size_zero) else $error("search ran with zero size"); // R3
	property p_scan_start;
		scan_start |=> (arc_state == ARC_SCAN) && (scan_idx == {1'b0, $past(shape_size)});
	endproperty
	a_scan_start: assert property (p_scan_start) else $error("search start offset wrong"); // R5
	property p_gain_up;
		apply && !entry_gain[2] && entry_gain[1:0] == 2'h1 && rx_gain < 2'h3
			|=> rx_gain == $past(rx_gain) + 2'h1;
	endproperty
	a_gain_up: assert property (p_gain_up) else $error("gain not raised by one"); // R12
	property p_gain_clamp;
		apply && !entry_gain[2] && rx_gain == 2'h3 |=> rx_gain == 2'h3;
	endproperty
	a_gain_clamp: assert property (p_gain_clamp) else $error("gain wrapped"); // R23
	property p_no_hit;
		(arc_state == ARC_SCAN) && !hit && !wr_rxctl |=> $stable(rx_gain);
	endproperty
	a_no_hit: assert property (p_no_hit) else $error("gain moved without match"); // R24
	property p_scan_ends;
		scan_start |=> ##[0:20] (arc_state == ARC_IDLE);
	endproperty
	a_scan_ends: assert property (p_scan_ends) else $error("search did not end"); // R8
	property p_trx_start;
		(trx_state == TRX_IDLE) && cmd_trx |=> (trx_state == TRX_WAIT_TX) && trx_active;
	endproperty
	a_trx_start: assert property (p_trx_start) else $error("transceive did not start"); // R16
	property p_never_idle;
		(trx_state != TRX_IDLE) && !cmd_idle |=> (trx_state != TRX_IDLE);
	endproperty
	a_never_idle: assert property (p_never_idle) else $error("transceive fell idle"); // R17
	property p_send;
		(trx_state == TRX_WAIT_TX) && wr_instr |=> tx_start ##1 !tx_start;
	endproperty
	a_send: assert property (p_send) else $error("send trigger lost"); // R19
endmodule

/* dv/arc_rf_partner.sv */
`timescale 1ns/1ps
// ==========================================================
// RF front end stand-in answering the transceive handshake
module arc_rf_partner (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Response speed select
	input wire logic slow,
	// Handshake with the block
	input wire logic tx_start,
	input wire logic rx_enable,
	output logic tx_done,
	output logic rx_done
);
	logic [4:0] tx_cnt;
	logic [4:0] rx_cnt;
	logic rx_prev;
	wire logic [4:0] dly = slow ? 5'h0C : 5'h01;
	// send then receive
	// Counts down after a start or a new receive window, then pulses done
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tx_cnt <= 5'h00;
			rx_cnt <= 5'h00;
			rx_prev <= 1'h0;
			tx_done <= 1'h0;
			rx_done <= 1'h0;
		end else begin
			rx_prev <= rx_enable;
			tx_done <= (tx_cnt == 5'h01);
			rx_done <= (rx_cnt == 5'h01);
			if (tx_start)
				tx_cnt <= dly;
			else if (tx_cnt != 5'h00)
				tx_cnt <= tx_cnt - 5'h01;
			if (rx_enable && !rx_prev)
				rx_cnt <= dly;
			else if (rx_cnt != 5'h00)
				rx_cnt <= rx_cnt - 5'h01;
		end
	end
endmodule

/* dv/adaptive_rx_ctrl_transceive_bench.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the adaptive receiver controller
module adaptive_rx_ctrl_transceive_bench;
	import arc_pkg::*;
	logic clock = 1'h0;
	logic reset_n = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [3:0] dpc_gear = 4'h0;
	logic slow = 1'h0;
	logic [31:0] reg_rdata;
	logic [1:0] rx_gain;
	logic [1:0] highpass_corner_field;
	logic [3:0] primary_min_threshold;
	logic [3:0] secondary_min_threshold;
	logic tx_start, rx_enable, trx_active, tx_done, rx_done;
	logic rd_seen = 1'h0;
	logic [31:0] exp_q[$];
	int fail_count = 0;
	int samples_checked = 0;
	int tx_count = 0;
	logic [3:0] v, s, g;
	logic [11:0] d;

	arc_adaptive_rx dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.dpc_gear(dpc_gear), .tx_done(tx_done), .rx_done(rx_done), .rx_gain(rx_gain),
		.highpass_corner_field(highpass_corner_field),
		.primary_min_threshold(primary_min_threshold),
		.secondary_min_threshold(secondary_min_threshold), .tx_start(tx_start),
		.rx_enable(rx_enable), .trx_active(trx_active));
	arc_rf_partner rf (.clock(clock), .reset_n(reset_n), .slow(slow), .tx_start(tx_start),
		.rx_enable(rx_enable), .tx_done(tx_done), .rx_done(rx_done));

	// Clock of 4 ns
	initial begin
		forever #2 clock = ~clock;
	end

	// ==========================================================
	// Checking and bus tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		@(posedge clock);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= dat;
		@(posedge clock);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd <= 1'h1;
		reg_addr <= a;
		exp_q.push_back(exp);
		@(posedge clock);
		reg_rd <= 1'h0;
	endtask
	task automatic gear(input logic [3:0] n);
		@(posedge clock);
		dpc_gear <= n;
		repeat (8) @(posedge clock);
	endtask
	task automatic wait_rx(input logic lvl);
		int i;
		for (i = 0; i < 60 && rx_enable !== lvl; i++)
			@(posedge clock);
		if (rx_enable !== lvl) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	function automatic logic [31:0] ent(input logic [15:0] m, input logic [11:0] dl,
		input logic [3:0] n);
		return {m, dl, n};
	endfunction
	function automatic logic [3:0] adj(input logic [3:0] x, input logic [2:0] dl,
		input logic [3:0] mx);
		int r;
		r = int'(x) + (dl[2] ? -int'(dl[1:0]) : int'(dl[1:0]));
		if (r < 0)
			r = 0;
		if (r > int'(mx))
			r = int'(mx);
		return 4'(r);
	endfunction

	// Read monitor takes the oldest expectation a cycle after each read
	always @(posedge clock) begin
		if (rd_seen)
			chk(reg_rdata, exp_q.pop_front());
		rd_seen <= reg_rd;
		if (tx_start === 1'h1)
			tx_count++;
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(47));
		repeat (8) @(posedge clock);
		reset_n <= 1'h1;
		rd(ADDR_SIZE, 32'h0);
		rd(ADDR_MODE, 32'h1);
		rd(ADDR_STATUS, 32'h110);
		wr(ADDR_STATUS, 32'hFFF);
		rd(ADDR_STATUS, 32'h110);
		rd(8'h40, 32'h0);
		$display("test reset done");
		// Two adaptive entries behind one shaping entry
		wr(ADDR_SIZE, 32'h21);
		wr(8'h00, ent(16'h0001, 12'hDB6, 4'h1));
		wr(8'h01, ent(16'h0001, 12'h2CA, 4'h1));
		wr(8'h02, ent(16'h0001, 12'h75F, 4'h2));
		rd(8'h02, ent(16'h0001, 12'h75F, 4'h2));
		wr(ADDR_RXCTL, 32'h0);
		wr(ADDR_SIGPRO, 32'h0);
		gear(4'h1);
		rd(ADDR_RXCTL, 32'h6);
		rd(ADDR_SIGPRO, 32'h13);
		chk(32'(primary_min_threshold), 32'h3);
		chk(32'(secondary_min_threshold), 32'h1);
		gear(4'h2);
		rd(ADDR_RXCTL, 32'hC);
		rd(ADDR_SIGPRO, 32'h42);
		gear(4'h1);
		rd(ADDR_RXCTL, 32'hE);
		rd(ADDR_SIGPRO, 32'h55);
		wr(ADDR_MODE, 32'h2);
		gear(4'h2);
		rd(ADDR_RXCTL, 32'hE);
		wr(ADDR_SIZE, 32'h01);
		wr(ADDR_MODE, 32'h1);
		gear(4'h1);
		rd(ADDR_RXCTL, 32'hE);
		rd(ADDR_SIGPRO, 32'h55);
		$display("test table done");
		// Random deltas on random start values
		// entries rewritten after resize
		wr(ADDR_SIZE, 32'h10);
		for (int i = 0; i < 8; i++) begin
			v = 4'($urandom);
			s = 4'($urandom);
			d = 12'($urandom);
			g = 4'($urandom_range(1, 15));
			gear(4'h0);
			wr(8'h00, ent(16'h0001, d, g));
			wr(ADDR_RXCTL, 32'(v));
			wr(ADDR_SIGPRO, {24'h0, s, s});
			gear(g);
			chk(32'(rx_gain), 32'(adj(v[3:2], d[5:3], GAIN_MAX)));
			chk(32'(highpass_corner_field), 32'(adj(v[1:0], d[2:0], HPCF_MAX)));
			chk(32'(primary_min_threshold), 32'(adj(s, d[8:6], MIN_MAX)));
			chk(32'(secondary_min_threshold), 32'(adj(s, d[11:9], MIN_MAX)));
		end
		$display("test random done");
		// Transceive start, both triggers, stray trigger, stop
		wr(ADDR_SYSCFG, 32'h3);
		repeat (2) @(posedge clock);
		chk(32'(trx_active), 32'h1);
		rd(ADDR_SYSCFG, 32'h3);
		wr(ADDR_SEND_INSTR, 32'h0);
		repeat (2) @(posedge clock);
		chk(32'(tx_count), 32'h1);
		wait_rx(1'h1);
		wait_rx(1'h0);
		slow <= 1'h1;
		wr(ADDR_SYSCFG, 32'hB);
		wait_rx(1'h1);
		wr(ADDR_SEND_INSTR, 32'h0);
		wait_rx(1'h0);
		chk(32'(tx_count), 32'h2);
		repeat (100) @(posedge clock);
		chk(32'(trx_active), 32'h1);
		wr(ADDR_SYSCFG, 32'h0);
		repeat (2) @(posedge clock);
		chk(32'(trx_active), 32'h0);
		rd(ADDR_SYSCFG, 32'h0);
		$display("test transceive done");
		repeat (4) @(posedge clock);
		report_and_stop();
	end
endmodule
